// ==== hw/dmcc_top.sv ====
// Purpose: command interpreter for sleep, display, inversion, gamma and tear sync
// Assumes: Wishbone classic slave, 32-bit data, 125 MHz clock
// Notes: commands written to the command register as opcode plus parameter
//
// Summary of operation
// - status bit 0 set when checksums differ
// - 10h starts power-down sleep-in sequence
// - 10h ignored while already asleep
// - every reset leaves device asleep
// - 11h starts power-up and register reload
// - 11h while awake changes nothing
// - 20h inversion off, 21h on, default off
// - gamma select one-hot, default 01h
// - invalid gamma code keeps current curve
// - 28h blanks output, off after reset
// - display on/off touch nothing else
// - 29h restores frame-memory output
// - redundant display on/off ignored
// - 34h disables tear output, held low
// - 34h ignored when tear already off
// - 35h parameter: width, polarity, mode
// - mode 0 vertical, mode 1 both blankings
// - sleep with tear on drives low
// - tear timing ignores line refresh order
// - polarity 0 high, 1 low
// - pulse lasts width plus one lines
//
// Local design decision: register access over Wishbone.
`default_nettype none
`include "dmcc_regs.svh"
module dmcc_top #(
	parameter int SEQ_CYCLES = `DMCC_SEQ_CYC
) (
	input wire logic clock, // system clock
	input wire logic nrst, // sync reset, active low
	input wire logic wb_cyc_i, // bus cycle
	input wire logic wb_stb_i, // strobe
	input wire logic wb_we_i, // write enable
	input wire logic [7:0] wb_adr_i, // byte address
	input wire logic [3:0] wb_sel_i, // byte lanes
	input wire logic [31:0] wb_dat_i, // write data
	output logic [31:0] wb_dat_o, // read data
	output logic wb_ack_o, // acknowledge
	input wire logic line_tick, // one pulse per panel line
	input wire logic frame_start, // first line of vertical porch
	input wire logic hblank, // horizontal blanking level
	input wire logic line_refresh_order, // memory_access_control order bit
	input wire logic cksum_mismatch, // checksum compare result
	output logic frame_sync_output, // tearing-effect pin
	output logic panel_output_en, // frame memory to panel
	output logic invert_on, // pixel inversion
	output logic power_on, // panel powered
	output logic reload_pulse // register reload request
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		dmcc_pkg::dmcc_pwr_t pwr;
		logic disp_on;
		logic inv_on;
		logic [7:0] gamma;
		logic [7:0] gamma_raw;
		logic tear_on;
		logic [7:0] tear_cfg;
		logic cksum;
		logic reload;
		logic ack;
		logic [31:0] rdata;
		logic power;
		logic panel;
		logic seq_go;
	} dmcc_st_t;
	dmcc_st_t s_q, s_d;

	logic seq_done;
	logic wr_cmd;
	logic rd_req;
	logic [7:0] op;
	logic [7:0] prm;
	logic order_unused;
	dmcc_tear_if tif ();

	function automatic logic gamma_valid(input logic [7:0] c);
		return c == `DMCC_GAMMA_C1 || c == `DMCC_GAMMA_C2 ||
			c == `DMCC_GAMMA_C3 || c == `DMCC_GAMMA_C4;
	endfunction : gamma_valid

	// ----------------------------------------
	// bus decode
	// ----------------------------------------
	assign op = wb_dat_i[15:8];
	assign prm = wb_dat_i[7:0];
	assign wr_cmd = wb_cyc_i && wb_stb_i && wb_we_i && !s_q.ack &&
		wb_adr_i == `DMCC_CMD_ADDR && wb_sel_i[1:0] == 2'h3;
	assign rd_req = wb_cyc_i && wb_stb_i && !wb_we_i && !s_q.ack;
	// tear timing deliberately never looks at refresh order
	assign order_unused = line_refresh_order;

	always_comb begin
		s_d = s_q;
		s_d.reload = 1'b0;
		s_d.seq_go = 1'b0;
		s_d.ack = wb_cyc_i && wb_stb_i && !s_q.ack;
		s_d.cksum = cksum_mismatch;
		s_d.rdata = 32'h00000000;
		if (rd_req) begin
			case (wb_adr_i)
				`DMCC_STATUS_ADDR: s_d.rdata = {24'h000000, s_q.tear_on, s_q.power,
					s_q.pwr == dmcc_pkg::PWR_AWAKE, s_q.disp_on, s_q.inv_on, 2'h0,
					s_q.cksum};
				(`DMCC_GAMMA_IDX << 2): s_d.rdata = {24'h000000, s_q.gamma};
				(`DMCC_TEAR_IDX << 2): s_d.rdata = {24'h000000, s_q.tear_cfg};
				default: s_d.rdata = 32'h00000000;
			endcase
		end
		if (wr_cmd) begin
			case (op)
				`DMCC_OP_SLEEP_IN: begin
					if (s_q.pwr == dmcc_pkg::PWR_AWAKE ||
						s_q.pwr == dmcc_pkg::PWR_WAKING) begin
						s_d.pwr = dmcc_pkg::PWR_FALLING;
						s_d.panel = 1'b0;
						s_d.seq_go = 1'b1;
					end
				end
				`DMCC_OP_SLEEP_OUT: begin
					if (s_q.pwr == dmcc_pkg::PWR_SLEEP ||
						s_q.pwr == dmcc_pkg::PWR_FALLING) begin
						s_d.pwr = dmcc_pkg::PWR_WAKING;
						s_d.power = 1'b1;
						s_d.reload = 1'b1;
						s_d.seq_go = 1'b1;
					end
				end
				`DMCC_OP_INV_OFF: s_d.inv_on = 1'b0;
				`DMCC_OP_INV_ON: s_d.inv_on = 1'b1;
				`DMCC_OP_GAMMA: begin
					s_d.gamma_raw = prm;
					if (gamma_valid(prm))
						s_d.gamma = prm;
				end
				`DMCC_OP_DISP_OFF: begin
					if (s_q.disp_on)
						s_d.disp_on = 1'b0;
				end
				`DMCC_OP_DISP_ON: begin
					if (!s_q.disp_on)
						s_d.disp_on = 1'b1;
				end
				`DMCC_OP_TEAR_OFF: begin
					if (s_q.tear_on)
						s_d.tear_on = 1'b0;
				end
				`DMCC_OP_TEAR_ON: begin
					s_d.tear_on = 1'b1;
					s_d.tear_cfg = prm & `DMCC_TEAR_MASK;
				end
				default: s_d.tear_on = s_q.tear_on;
			endcase
		end
		case (s_q.pwr)
			dmcc_pkg::PWR_WAKING: if (seq_done) s_d.pwr = dmcc_pkg::PWR_AWAKE;
			dmcc_pkg::PWR_FALLING: if (seq_done) begin
				s_d.pwr = dmcc_pkg::PWR_SLEEP;
				s_d.power = 1'b0;
			end
			default: s_d.pwr = s_d.pwr;
		endcase
		// display on/off only gate output; memory and modes untouched
		if (s_d.pwr == dmcc_pkg::PWR_AWAKE)
			s_d.panel = s_d.disp_on;
		else
			s_d.panel = 1'b0;
	end

	always_ff @(posedge clock) begin
		if (!nrst) begin
			s_q <= '0;
			s_q.pwr <= dmcc_pkg::PWR_SLEEP;
			s_q.gamma <= `DMCC_GAMMA_RST;
			s_q.gamma_raw <= `DMCC_GAMMA_RST;
			s_q.tear_cfg <= `DMCC_TEAR_RST;
			s_q.cksum <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------
	// submodules
	// ----------------------------------------
	dmcc_timer #(
		.CYCLES(SEQ_CYCLES)
	) u_timer (
		.clock(clock),
		.nrst(nrst),
		.start(s_q.seq_go),
		.done(seq_done)
	);

	assign tif.enable = s_q.tear_on;
	assign tif.force_low = s_q.pwr != dmcc_pkg::PWR_AWAKE;
	assign tif.mode = s_q.tear_cfg[`DMCC_TEAR_MODE_BIT];
	assign tif.polarity = s_q.tear_cfg[`DMCC_TEAR_POL_BIT];
	assign tif.width = s_q.tear_cfg[`DMCC_TEAR_WID_LSB +: 4];
	assign tif.line_tick = line_tick;
	assign tif.frame_start = frame_start;
	assign tif.hblank = hblank;

	dmcc_tear_gen u_tear (
		.clock(clock),
		.nrst(nrst),
		.tif(tif)
	);

	assign frame_sync_output = tif.te;
	assign wb_ack_o = s_q.ack;
	assign wb_dat_o = s_q.rdata;
	assign panel_output_en = s_q.panel;
	assign invert_on = s_q.inv_on;
	assign power_on = s_q.power;
	assign reload_pulse = s_q.reload;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	sequence s_sleep_cmd;
		wr_cmd && op == `DMCC_OP_SLEEP_IN;
	endsequence
	property p_sleep_in;
		@(posedge clock) disable iff (!nrst)
			s_sleep_cmd and s_q.pwr == dmcc_pkg::PWR_AWAKE |=> s_q.pwr == dmcc_pkg::PWR_FALLING;
	endproperty
	a_sleep_in: assert property (p_sleep_in) else $error("sleep-in not started");
	property p_sleep_ign;
		@(posedge clock) disable iff (!nrst)
			s_sleep_cmd and s_q.pwr == dmcc_pkg::PWR_SLEEP |=> s_q.pwr == dmcc_pkg::PWR_SLEEP;
	endproperty
	a_sleep_ign: assert property (p_sleep_ign) else $error("sleep-in not ignored");
	property p_wake;
		@(posedge clock) disable iff (!nrst)
			wr_cmd && op == `DMCC_OP_SLEEP_OUT && s_q.pwr == dmcc_pkg::PWR_SLEEP
			|=> reload_pulse && power_on;
	endproperty
	a_wake: assert property (p_wake) else $error("sleep-out no reload");
	property p_wake_ign;
		@(posedge clock) disable iff (!nrst)
			wr_cmd && op == `DMCC_OP_SLEEP_OUT && s_q.pwr == dmcc_pkg::PWR_AWAKE
			|=> !reload_pulse && $stable(panel_output_en);
	endproperty
	a_wake_ign: assert property (p_wake_ign) else $error("sleep-out visible when awake");
	property p_inv;
		@(posedge clock) disable iff (!nrst)
			wr_cmd && op == `DMCC_OP_INV_ON |=> invert_on;
	endproperty
	a_inv: assert property (p_inv) else $error("inversion not on");
	property p_gamma_bad;
		@(posedge clock) disable iff (!nrst)
			wr_cmd && op == `DMCC_OP_GAMMA && !gamma_valid(prm) |=> $stable(s_q.gamma);
	endproperty
	a_gamma_bad: assert property (p_gamma_bad) else $error("invalid gamma accepted");
	property p_disp_off;
		@(posedge clock) disable iff (!nrst)
			wr_cmd && op == `DMCC_OP_DISP_OFF |=> ##1 !panel_output_en;
	endproperty
	a_disp_off: assert property (p_disp_off) else $error("display not blanked");
	property p_disp_keep;
		@(posedge clock) disable iff (!nrst)
			wr_cmd && (op == `DMCC_OP_DISP_ON || op == `DMCC_OP_DISP_OFF)
			|=> $stable(s_q.inv_on) && $stable(s_q.gamma) && $stable(s_q.tear_cfg);
	endproperty
	a_disp_keep: assert property (p_disp_keep) else $error("display cmd changed state");
	property p_tear_cfg;
		@(posedge clock) disable iff (!nrst)
			wr_cmd && op == `DMCC_OP_TEAR_ON |=> s_q.tear_cfg[3:2] == 2'h0 && s_q.tear_on;
	endproperty
	a_tear_cfg: assert property (p_tear_cfg) else $error("tear parameter wrong");
	sequence s_wake_cmd;
		wr_cmd && op == `DMCC_OP_SLEEP_OUT;
	endsequence
	sequence s_tear_off_cmd;
		wr_cmd && op == `DMCC_OP_TEAR_OFF;
	endsequence
	// reset checks carry no disable, so the cleared state itself is seen
	property p_rst_pwr;
		@(posedge clock)
			!nrst |=> s_q.pwr == dmcc_pkg::PWR_SLEEP && !power_on && !panel_output_en;
	endproperty
	a_rst_pwr: assert property (p_rst_pwr) else $error("reset not asleep");
	property p_rst_modes;
		@(posedge clock)
			!nrst |=> !s_q.disp_on && !s_q.tear_on && !s_q.inv_on;
	endproperty
	a_rst_modes: assert property (p_rst_modes) else $error("reset modes");
	property p_rst_regs;
		@(posedge clock)
			!nrst |=> s_q.gamma == `DMCC_GAMMA_RST && s_q.tear_cfg == `DMCC_TEAR_RST;
	endproperty
	a_rst_regs: assert property (p_rst_regs) else $error("reset registers");
	property p_cksum;
		@(posedge clock) disable iff (!nrst)
			nrst |=> s_q.cksum == $past(cksum_mismatch);
	endproperty
	a_cksum: assert property (p_cksum) else $error("checksum flag stale");
	property p_inv_off;
		@(posedge clock) disable iff (!nrst)
			wr_cmd && op == `DMCC_OP_INV_OFF |=> !invert_on;
	endproperty
	a_inv_off: assert property (p_inv_off) else $error("inversion not off");
	property p_gamma_ok;
		@(posedge clock) disable iff (!nrst)
			wr_cmd && op == `DMCC_OP_GAMMA && gamma_valid(prm) |=> s_q.gamma == $past(prm);
	endproperty
	a_gamma_ok: assert property (p_gamma_ok) else $error("valid gamma lost");
	property p_disp_on;
		@(posedge clock) disable iff (!nrst)
			wr_cmd && op == `DMCC_OP_DISP_ON && s_q.pwr == dmcc_pkg::PWR_AWAKE |=> panel_output_en;
	endproperty
	a_disp_on: assert property (p_disp_on) else $error("display not restored");
	property p_disp_off_ign;
		@(posedge clock) disable iff (!nrst)
			wr_cmd && op == `DMCC_OP_DISP_OFF && !s_q.disp_on |=> !s_q.disp_on && !panel_output_en;
	endproperty
	a_disp_off_ign: assert property (p_disp_off_ign) else $error("extra off acted");
	property p_disp_on_ign;
		@(posedge clock) disable iff (!nrst)
			wr_cmd && op == `DMCC_OP_DISP_ON && s_q.disp_on |=> s_q.disp_on;
	endproperty
	a_disp_on_ign: assert property (p_disp_on_ign) else $error("extra on acted");
	property p_tear_off;
		@(posedge clock) disable iff (!nrst)
			s_tear_off_cmd |=> !s_q.tear_on ##2 !frame_sync_output;
	endproperty
	a_tear_off: assert property (p_tear_off) else $error("tear output not stopped");
	property p_tear_ign;
		@(posedge clock) disable iff (!nrst)
			s_tear_off_cmd and !s_q.tear_on |=> !s_q.tear_on && $stable(s_q.tear_cfg);
	endproperty
	a_tear_ign: assert property (p_tear_ign) else $error("tear-off not ignored");
	// panel may only see frame memory once the power-up sequence has finished
	property p_panel_awake;
		@(posedge clock) disable iff (!nrst)
			s_q.pwr != dmcc_pkg::PWR_AWAKE |-> !panel_output_en;
	endproperty
	a_panel_awake: assert property (p_panel_awake) else $error("panel on while asleep");
	property p_wake_seq;
		@(posedge clock) disable iff (!nrst)
			s_wake_cmd and s_q.pwr == dmcc_pkg::PWR_SLEEP
			|=> s_q.pwr == dmcc_pkg::PWR_WAKING && s_q.seq_go;
	endproperty
	a_wake_seq: assert property (p_wake_seq) else $error("power-up not started");
	property p_fall_seq;
		@(posedge clock) disable iff (!nrst)
			s_sleep_cmd and s_q.pwr == dmcc_pkg::PWR_AWAKE |=> !panel_output_en && s_q.seq_go;
	endproperty
	a_fall_seq: assert property (p_fall_seq) else $error("power-down not started");
endmodule : dmcc_top
`default_nettype wire

// ==== hw/dmcc_regs.svh ====
// Purpose: register offsets, reset values and timing counts of the display mode control
// Assumes: 125 MHz system clock
// Notes: offsets are byte addresses of 32-bit words (index times four)
`ifndef DMCC_REGS_SVH
`define DMCC_REGS_SVH
// ----------------------------------------
// register map
// ----------------------------------------
`define DMCC_CMD_ADDR 8'h00
`define DMCC_STATUS_ADDR 8'h04
`define DMCC_TIMING_ADDR 8'h08
`define DMCC_GAMMA_IDX 8'h26
`define DMCC_TEAR_IDX 8'h35
// ----------------------------------------
// command codes
// ----------------------------------------
`define DMCC_OP_SLEEP_IN 8'h10
`define DMCC_OP_SLEEP_OUT 8'h11
`define DMCC_OP_INV_OFF 8'h20
`define DMCC_OP_INV_ON 8'h21
`define DMCC_OP_GAMMA 8'h26
`define DMCC_OP_DISP_OFF 8'h28
`define DMCC_OP_DISP_ON 8'h29
`define DMCC_OP_TEAR_OFF 8'h34
`define DMCC_OP_TEAR_ON 8'h35
// ----------------------------------------
// reset values and field positions
// ----------------------------------------
`define DMCC_GAMMA_RST 8'h01
`define DMCC_GAMMA_C1 8'h01
`define DMCC_GAMMA_C2 8'h02
`define DMCC_GAMMA_C3 8'h04
`define DMCC_GAMMA_C4 8'h08
`define DMCC_TEAR_RST 8'h00
`define DMCC_TEAR_MASK 8'hF3
`define DMCC_TEAR_MODE_BIT 0
`define DMCC_TEAR_POL_BIT 1
`define DMCC_TEAR_WID_LSB 4
`define DMCC_CKSUM_BIT 0
// ----------------------------------------
// timing
// ----------------------------------------
`define DMCC_CLK_MHZ 125
`define DMCC_SEQ_US 20000
`define DMCC_SEQ_CYC (`DMCC_SEQ_US * `DMCC_CLK_MHZ)
`endif

// ==== hw/dmcc_pkg.sv ====
// Purpose: shared types of the display mode control
// Assumes: nothing
// Notes: constants live in dmcc_regs.svh
`default_nettype none
package dmcc_pkg;
	typedef enum logic [1:0] {
		PWR_SLEEP,
		PWR_WAKING,
		PWR_AWAKE,
		PWR_FALLING
	} dmcc_pwr_t;
endpackage : dmcc_pkg
`default_nettype wire

// ==== hw/dmcc_tear_if.sv ====
// Purpose: carries tear output settings and line timing to the sync generator
// Assumes: single clock
// Notes: none
`default_nettype none
interface dmcc_tear_if;
	logic enable;
	logic force_low;
	logic mode;
	logic polarity;
	logic [3:0] width;
	logic line_tick;
	logic frame_start;
	logic hblank;
	logic te;
	modport ctrl (output enable, force_low, mode, polarity, width, line_tick, frame_start,
		hblank, input te);
	modport gen (input enable, force_low, mode, polarity, width, line_tick, frame_start,
		hblank, output te);
endinterface : dmcc_tear_if
`default_nettype wire

// ==== hw/dmcc_tear_gen.sv ====
// Purpose: builds the tearing-effect sync level from line timing and settings
// Assumes: line_tick pulses once per line, frame_start once per frame on a line tick
// Notes: output registered
`default_nettype none
module dmcc_tear_gen (
	input wire logic clock, // system clock
	input wire logic nrst, // sync reset, active low
	dmcc_tear_if.gen tif // settings and timing
);
	typedef struct packed {
		logic [4:0] left;
		logic te;
	} dmcc_tg_st_t;
	dmcc_tg_st_t s_q, s_d;
	logic active;

	always_comb begin
		s_d = s_q;
		if (tif.frame_start)
			s_d.left = 5'(tif.width) + 5'h01;
		else if (tif.line_tick && s_q.left != 5'h00)
			s_d.left = s_q.left - 5'h01;
		// mode 0 vertical only; mode 1 adds horizontal blanking
		active = (s_q.left != 5'h00) || (tif.mode && tif.hblank);
		if (!tif.enable)
			s_d.te = 1'b0;
		else if (tif.force_low)
			s_d.te = 1'b0;
		else
			s_d.te = active ^ tif.polarity;
	end

	always_ff @(posedge clock) begin
		if (!nrst)
			s_q <= '0;
		else
			s_q <= s_d;
	end
	assign tif.te = s_q.te;

	property p_off_low;
		@(posedge clock) disable iff (!nrst) !tif.enable |=> !s_q.te;
	endproperty
	a_off_low: assert property (p_off_low) else $error("tear out not low when off");
	property p_sleep_low;
		@(posedge clock) disable iff (!nrst) tif.enable && tif.force_low |=> !s_q.te;
	endproperty
	a_sleep_low: assert property (p_sleep_low) else $error("tear out not low in sleep");
	property p_width;
		@(posedge clock) disable iff (!nrst)
			tif.frame_start |=> s_q.left == 5'($past(tif.width)) + 5'h01;
	endproperty
	a_width: assert property (p_width) else $error("pulse line count wrong");
endmodule : dmcc_tear_gen
`default_nettype wire

// ==== hw/dmcc_timer.sv ====
// Purpose: one-shot cycle counter for power sequences
// Assumes: start is a one-cycle pulse
// Notes: done pulses once when the count runs out
`default_nettype none
module dmcc_timer #(
	parameter int CYCLES = 2500000
) (
	input wire logic clock, // system clock
	input wire logic nrst, // sync reset, active low
	input wire logic start, // begin counting
	output logic done // one-cycle end pulse
);
	typedef struct packed {
		logic [31:0] cnt;
		logic run;
		logic done;
	} dmcc_tm_st_t;
	dmcc_tm_st_t s_q, s_d;

	always_comb begin
		s_d = s_q;
		s_d.done = 1'b0;
		if (start) begin
			s_d.cnt = 32'(CYCLES - 1);
			s_d.run = 1'b1;
		end else if (s_q.run) begin
			if (s_q.cnt == 32'h00000000) begin
				s_d.run = 1'b0;
				s_d.done = 1'b1;
			end else begin
				s_d.cnt = s_q.cnt - 32'h00000001;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (!nrst)
			s_q <= '0;
		else
			s_q <= s_d;
	end
	assign done = s_q.done;
endmodule : dmcc_timer
`default_nettype wire

// ==== test/dmcc_line_model.sv ====
// Purpose: panel line timing source feeding the tear sync inputs
// Assumes: line_tick on the first cycle of every line
// Notes: hblank covers the first HB cycles of every line
`default_nettype none
module dmcc_line_model #(
	parameter int LC = 8,
	parameter int NL = 20,
	parameter int HB = 2
) (
	input wire logic clock, // system clock
	input wire logic nrst, // sync reset, active low
	output logic line_tick, // line pulse
	output logic frame_start, // frame pulse, with a line tick
	output logic hblank // horizontal blanking level
);
	timeunit 1ns;
	timeprecision 1ps;
	int pos;
	int line;
	always @(posedge clock) begin
		if (nrst !== 1'h1) begin
			pos <= 0;
			line <= 0;
		end else begin
			pos <= (pos == LC - 1) ? 0 : pos + 1;
			if (pos == LC - 1) line <= (line == NL - 1) ? 0 : line + 1;
		end
	end
	assign line_tick = (pos == 0);
	assign frame_start = (pos == 0) && (line == 0);
	assign hblank = (pos < HB);
endmodule : dmcc_line_model
`default_nettype wire

// ==== test/display_mode_command_control_tb.sv ====
// Purpose: self-checking bench of the display mode command control
// Assumes: one 125 MHz clock, Wishbone classic master in the bench
// Notes: power sequence shortened to SEQ cycles
`default_nettype none
module display_mode_command_control_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int SEQ = 20;
	localparam int LC = 8;
	localparam int NL = 20;
	localparam int HB = 2;
	logic clock, nrst, cyc, stb, we, cks, lro;
	logic [7:0] adr, p, v;
	logic [3:0] sel;
	logic [31:0] dat, dat_o, q;
	logic ack, fso, pen, inv, pwr, rld, lt, fs, hb;
	int bad_count, samples_checked, reloads, c;
	logic [7:0] plist [4];
	dmcc_top #(.SEQ_CYCLES(SEQ)) uut (.clock(clock), .nrst(nrst), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
		.wb_dat_o(dat_o), .wb_ack_o(ack), .line_tick(lt), .frame_start(fs), .hblank(hb),
		.line_refresh_order(lro), .cksum_mismatch(cks), .frame_sync_output(fso),
		.panel_output_en(pen), .invert_on(inv), .power_on(pwr), .reload_pulse(rld));
	dmcc_line_model #(.LC(LC), .NL(NL), .HB(HB)) lines (.clock(clock), .nrst(nrst),
		.line_tick(lt), .frame_start(fs), .hblank(hb));
	initial begin
		clock = 1'h0;
		forever #4 clock = ~clock;
	end
	always @(posedge clock) begin
		lro <= 1'($urandom);
		if (rld === 1'h1) reloads++;
	end
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic complete_run;
		$display("checks %0d errors %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : complete_run
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			$display("[ERR] %s expected %0h seen %0h", nm, e, g);
			bad_count++;
		end
	endtask : chk
	task automatic wt(input int n);
		repeat (n) @(negedge clock);
	endtask : wt
	// ack looked at mid-cycle, so it is the value the next rising edge samples
	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clock);
		cyc <= 1'h1;
		stb <= 1'h1;
		we <= w;
		adr <= a;
		dat <= d;
		do begin
			@(negedge clock);
			n++;
		end while (ack !== 1'h1 && n < 50);
		if (n >= 50) chk("ack", 32'h1, 32'h0);
		@(posedge clock);
		q = dat_o;
		cyc <= 1'h0;
		stb <= 1'h0;
		we <= 1'h0;
	endtask : bus
	task automatic cmd(input logic [7:0] op, input logic [7:0] pr);
		bus(8'h00, 1'h1, {16'h0000, op, pr});
		wt(3);
	endtask : cmd
	task automatic rd(input logic [7:0] a);
		bus(a, 1'h0, 32'h0);
	endtask : rd
	// one frame window: the count is the same wherever it starts
	task automatic te_count(input logic act);
		c = 0;
		repeat (LC * NL) begin
			@(negedge clock);
			if (fso === act) c++;
		end
	endtask : te_count
	function automatic logic [31:0] stat(input logic k, i, d, a, w, t);
		return {24'h000000, t, w, a, d, i, 3'h0} | 32'(k);
	endfunction : stat
	function automatic int te_exp(input logic [7:0] pr);
		return (int'(pr[7:4]) + 1) * LC + (pr[0] ? (NL - 1 - int'(pr[7:4])) * HB : 0);
	endfunction : te_exp
	function automatic bit listed(input logic [7:0] g);
		return g == 8'h01 || g == 8'h02 || g == 8'h04 || g == 8'h08;
	endfunction : listed
	initial begin
		#200000;
		bad_count++;
		complete_run();
	end
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		{cyc, stb, we, nrst} = 4'h0;
		adr = 8'h00;
		sel = 4'hF;
		dat = 32'h0;
		cks = 1'h1;
		void'($urandom(58298));
		plist = '{8'h00, 8'hF3, 8'h0C, 8'(($urandom))};
		repeat (2) @(posedge clock);
		nrst <= 1'h1;
		@(posedge clock);
		rd(8'h04);
		chk("status", stat(1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0), q);
		rd(8'h98);
		chk("gamma", 32'h1, q);
		rd(8'hD4);
		chk("tearcfg", 32'h0, q);
		rd(8'h08);
		chk("unmapped", 32'h0, q);
		chk("outs", 32'h0, {28'h0, pen, inv, pwr, fso});
		bus(8'h08, 1'h1, 32'h00002900);
		cmd(8'h10, 8'h00);
		rd(8'h04);
		chk("status", stat(1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0), q);
		cmd(8'h29, 8'h00);
		cmd(8'h29, 8'h00);
		rd(8'h04);
		chk("status", stat(1'h1, 1'h0, 1'h1, 1'h0, 1'h0, 1'h0), q);
		chk("panel", 32'h0, 32'(pen));
		cmd(8'h11, 8'h00);
		chk("reload", 32'h1, 32'(reloads));
		chk("power", 32'h1, 32'(pwr));
		wt(SEQ + 10);
		chk("panel", 32'h1, 32'(pen));
		cmd(8'h11, 8'h00);
		chk("reload", 32'h1, 32'(reloads));
		rd(8'h04);
		chk("status", stat(1'h1, 1'h0, 1'h1, 1'h1, 1'h1, 1'h0), q);
		for (int i = 0; i < 4; i++) begin
			cmd(i[0] ? 8'h21 : 8'h20, 8'h00);
			chk("invert", 32'(i[0]), 32'(inv));
		end
		cmd(8'h28, 8'h00);
		cmd(8'h28, 8'h00);
		chk("panel", 32'h0, 32'(pen));
		rd(8'h04);
		chk("status", stat(1'h1, 1'h1, 1'h0, 1'h1, 1'h1, 1'h0), q);
		cmd(8'h29, 8'h00);
		chk("panel", 32'h1, 32'(pen));
		for (int i = 0; i < 4; i++) begin
			p = 8'h01 << ((i + 1) % 4);
			cmd(8'h26, p);
			wt(SEQ);
			rd(8'h98);
			chk("gamma", 32'(p), q);
			do v = 8'($urandom); while (listed(v));
			cmd(8'h26, v);
			wt(SEQ);
			rd(8'h98);
			chk("gamma", 32'(p), q);
		end
		for (int i = 0; i < 3; i++) begin
			@(posedge clock);
			cks <= 1'($urandom);
			wt(SEQ);
			rd(8'h04);
			chk("cksum", 32'(cks), 32'(q[0]));
		end
		for (int i = 0; i < 4; i++) begin
			cmd(8'h35, plist[i]);
			rd(8'hD4);
			chk("tearcfg", 32'(plist[i] & 8'hF3), q);
			wt(2 * LC * NL);
			te_count(~plist[i][1]);
			chk("te", 32'(te_exp(plist[i])), 32'(c));
		end
		cmd(8'h34, 8'h00);
		cmd(8'h34, 8'h00);
		te_count(1'h1);
		chk("te_off", 32'h0, 32'(c));
		rd(8'h04);
		chk("status", stat(cks, 1'h1, 1'h1, 1'h1, 1'h1, 1'h0), q);
		cmd(8'h35, 8'h12);
		cmd(8'h10, 8'h00);
		chk("panel", 32'h0, 32'(pen));
		te_count(1'h1);
		chk("te_sleep", 32'h0, 32'(c));
		chk("power", 32'h0, 32'(pwr));
		cmd(8'h10, 8'h00);
		rd(8'h04);
		chk("status", stat(cks, 1'h1, 1'h1, 1'h0, 1'h0, 1'h1), q);
		cmd(8'h26, 8'h02);
		wt(SEQ);
		@(posedge clock);
		nrst <= 1'h0;
		repeat (2) @(posedge clock);
		nrst <= 1'h1;
		@(posedge clock);
		rd(8'h04);
		chk("status", stat(cks, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0), q);
		rd(8'h98);
		chk("gamma", 32'h1, q);
		rd(8'hD4);
		chk("tearcfg", 32'h0, q);
		chk("outs", 32'h0, {28'h0, pen, inv, pwr, fso});
		complete_run();
	end
endmodule : display_mode_command_control_tb
`default_nettype wire
